// ---- core/tws_slave.sv ----
/*
 * Serial EEPROM two-wire slave bus layer: Start/Stop detection, nine-clock
 * byte framing, address match, acknowledge and Standby handling.
 * Assumes SCL and SDA arrive from the bus asynchronously; a 4-word FIFO
 * carries transmit bytes from the user side in.
 */
// What this block does
// - Sample on SCL rise, drive after fall.
// - MSB first, eight bits plus ack.
// - Master clocks bytes without gaps.
// - SDA changes only while SCL low.
// - SDA fall with SCL high is Start.
// - Ignore bus until Start seen.
// - SDA rise with SCL high is Stop.
// - Stop enters Standby unless write starts.
// - Repeated Start begins new operation.
// - Idle only when both lines high.
// - Transmitter releases; receiver acks ninth high.
// - Receiver releases SDA after ninth cycle, except after a read address whose first data bit is 0.
// - Master NACK stops device transmit, releases.
// - Standby after power-up reset.
// - Standby when internal write finishes.
// - Master clocks up to nine, then Start.
// - SDA open-drain low only; SCL input.
// - No byte count limit per transfer.
// - Match 1010, select bits, then R/W.
// - No address ack while write busy.
`timescale 1ns/1ps
module tws_slave
    import tws_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    tws_bus_if.slave bus,
    input wire logic hw_select_bit_high_in,
    input wire logic hw_select_bit_mid_in,
    input wire logic hw_select_bit_low_in,
    input wire logic write_busy_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic write_req_out,
    output logic standby_out,
    output logic selected_out
);
    import tws_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_m_r <= bus.scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    always_comb
    begin
        scl_rise = scl_s_r & ~scl_d_r;
        scl_fall = ~scl_s_r & scl_d_r;
        start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
        stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    end

    // ------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------
    logic [7:0] fifo_data;
    logic fifo_valid, fifo_pop;

    tws_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wr_data_in(tx_data_in),
        .wr_valid_in(tx_valid_in),
        .wr_ready_out(tx_ready_out),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    tws_slv_state_e state_r, state_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
    logic sda_low_r, sda_low_nxt, ack_r, ack_nxt, got_data_r, got_data_nxt;
    logic rxv_r, rxv_nxt, wreq_r, wreq_nxt, stby_r, stby_nxt, sel_r, sel_nxt;
    logic [2:0] hw_sel;

    always_comb
    begin
        hw_sel = {hw_select_bit_high_in, hw_select_bit_mid_in, hw_select_bit_low_in};
        state_nxt = state_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        sda_low_nxt = sda_low_r;
        ack_nxt = ack_r;
        got_data_nxt = got_data_r;
        rxv_nxt = 1'b0;
        wreq_nxt = 1'b0;
        stby_nxt = stby_r;
        sel_nxt = sel_r;
        fifo_pop = 1'b0;
        if (start_det)
        begin
            // Abort any byte in flight and restart framing
            state_nxt = TWS_ADDR;
            bit_nxt = BIT_CNT_ZERO - 4'h1; // The Start's own SCL fall wraps this to zero
            sda_low_nxt = 1'b0;
            stby_nxt = 1'b0;
            sel_nxt = 1'b0;
            got_data_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            state_nxt = TWS_STANDBY;
            bit_nxt = BIT_CNT_ZERO;
            sda_low_nxt = 1'b0;
            sel_nxt = 1'b0;
            wreq_nxt = got_data_r;
            stby_nxt = ~got_data_r;
            got_data_nxt = 1'b0;
        end
        else if (state_r != TWS_STANDBY && state_r != TWS_IGNORE)
        begin
            if (scl_rise)
            begin
                if (bit_r == BIT_CNT_ACK)
                begin
                    ack_nxt = ~sda_s_r;
                end
                else if (state_r != TWS_TX)
                begin
                    sh_nxt = {sh_r[6:0], sda_s_r};
                end
            end
            else if (scl_fall)
            begin
                if (bit_r == BIT_CNT_LAST)
                begin
                    bit_nxt = BIT_CNT_ACK;
                    sda_low_nxt = 1'b0;
                    if (state_r == TWS_ADDR)
                    begin
                        if (sh_r[TYPE_MSB:TYPE_LSB] == TYPE_PATTERN && sh_r[SEL_MSB:SEL_LSB] == hw_sel
                            && !write_busy_in)
                        begin
                            sda_low_nxt = 1'b1;
                            sel_nxt = 1'b1;
                        end
                    end
                    else if (state_r == TWS_RX)
                    begin
                        sda_low_nxt = 1'b1;
                        rx_nxt = sh_r;
                        rxv_nxt = 1'b1;
                        got_data_nxt = 1'b1;
                    end
                end
                else if (bit_r == BIT_CNT_ACK)
                begin
                    bit_nxt = BIT_CNT_ZERO;
                    sda_low_nxt = 1'b0;
                    if (state_r == TWS_ADDR)
                    begin
                        if (!sel_r)
                        begin
                            state_nxt = TWS_IGNORE;
                        end
                        else
                        begin
                            state_nxt = sh_r[RW_BIT] ? TWS_TX : TWS_RX;
                        end
                    end
                    if (state_nxt == TWS_TX && (state_r == TWS_ADDR || ack_r))
                    begin
                        // Idle byte is all ones when no data queued
                        sh_nxt = fifo_valid ? fifo_data : IDLE_BYTE;
                        fifo_pop = fifo_valid;
                        sda_low_nxt = ~sh_nxt[TYPE_MSB];
                    end
                    else if (state_r == TWS_TX)
                    begin
                        state_nxt = TWS_IGNORE;
                    end
                end
                else
                begin
                    bit_nxt = bit_r + 4'h1;
                    if (state_r == TWS_TX)
                    begin
                        sh_nxt = {sh_r[6:0], 1'b1};
                        sda_low_nxt = ~sh_r[6];
                    end
                end
            end
        end
        if (!write_busy_in && state_r == TWS_STANDBY && !start_det)
        begin
            stby_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= TWS_STANDBY;
            bit_r <= BIT_CNT_ZERO;
            sh_r <= '0;
            rx_r <= '0;
            sda_low_r <= 1'b0;
            ack_r <= 1'b0;
            got_data_r <= 1'b0;
            rxv_r <= 1'b0;
            wreq_r <= 1'b0;
            stby_r <= 1'b1;
            sel_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            sda_low_r <= sda_low_nxt;
            ack_r <= ack_nxt;
            got_data_r <= got_data_nxt;
            rxv_r <= rxv_nxt;
            wreq_r <= wreq_nxt;
            stby_r <= stby_nxt;
            sel_r <= sel_nxt;
        end
    end

    // SDA only ever pulled low; SCL never driven
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_low_r;
    assign rx_data_out = rx_r;
    assign rx_valid_out = rxv_r;
    assign write_req_out = wreq_r;
    assign standby_out = stby_r;
    assign selected_out = sel_r;
endmodule

// ---- core/tws_pkg.sv ----
/*
 * Shared constants and types for the two-wire slave bus layer and its master.
 * Assumes both ends run on one 100 MHz system clock and meet over tws_bus_if.
 */
package tws_pkg;
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned ACK_CYCLE = 9;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    localparam logic [3:0] BIT_CNT_ACK = 4'h8;
    localparam logic [3:0] TYPE_PATTERN = 4'ha;
    localparam int unsigned TYPE_MSB = 7;
    localparam int unsigned TYPE_LSB = 4;
    localparam int unsigned SEL_MSB = 3;
    localparam int unsigned SEL_LSB = 1;
    localparam int unsigned RW_BIT = 0;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    // Half period of the master's generated SCL, in nanoseconds
    localparam int unsigned SCL_HALF_NS = 400;
    localparam int unsigned SYS_CLK_NS = 10;
    localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS / SYS_CLK_NS);
    localparam logic [3:0] RECOVER_CYCLES = 4'h9;
    localparam int unsigned FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        TWS_STANDBY = 3'b000,
        TWS_ADDR    = 3'b001,
        TWS_RX      = 3'b010,
        TWS_TX      = 3'b011,
        TWS_IGNORE  = 3'b100
    } tws_slv_state_e;

    typedef enum logic [2:0] {
        TWM_IDLE    = 3'b000,
        TWM_START   = 3'b001,
        TWM_BIT     = 3'b010,
        TWM_STOP    = 3'b011,
        TWM_RECOVER = 3'b100
    } tws_mst_state_e;
endpackage

// ---- core/tws_bus_if.sv ----
/*
 * Two-wire bus carrier: open-drain SDA and SCL wired-AND with pull-ups.
 * Assumes the bench instantiates it and connects both end modules.
 */
`timescale 1ns/1ps
interface tws_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Pull-ups make an undriven line read high; any driver pulls low
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);

    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

// ---- core/tws_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides share the system clock.
 */
`timescale 1ns/1ps
module tws_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic do_wr, do_rd;

    always_comb
    begin
        do_wr = wr_valid_in & wr_ready_out;
        do_rd = rd_valid_out & rd_ready_in;
        wptr_nxt = do_wr ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt = do_rd ? rptr_r + 1'b1 : rptr_r;
        wr_ready_out = (wptr_r[PW] == rptr_r[PW]) || (wptr_r[PW-1:0] != rptr_r[PW-1:0]);
        rd_valid_out = (wptr_r != rptr_r);
        rd_data_out = mem_r[rptr_r[PW-1:0]];
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
        end
        else
        begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (do_wr)
        begin
            mem_r[wptr_r[PW-1:0]] <= wr_data_in;
        end
    end
endmodule

// ---- core/tws_master.sv ----
/*
 * Two-wire bus master: generates SCL by division, Start, bytes with ack,
 * Stop, and the nine-clock recovery sequence.
 * Assumes one command at a time from the user side.
 */
`timescale 1ns/1ps
module tws_master
    import tws_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    tws_bus_if.master bus,
    input wire logic cmd_start_in,
    input wire logic cmd_byte_in,
    input wire logic cmd_stop_in,
    input wire logic cmd_recover_in,
    input wire logic [7:0] wr_byte_in,
    input wire logic ack_send_in,
    output logic busy_out,
    output logic [7:0] rd_byte_out,
    output logic ack_seen_out,
    output logic done_out
);
    import tws_pkg::*;

    // ------------------------------------------------------------
    // SDA sampling
    // ------------------------------------------------------------
    logic sda_m_r, sda_s_r;
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end
        else
        begin
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    tws_mst_state_e st_r, st_nxt;
    logic [7:0] div_r, div_nxt, sh_r, sh_nxt, rd_r, rd_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic phase_r, phase_nxt, scl_r, scl_nxt, sda_r, sda_nxt;
    logic ack_r, ack_nxt, done_r, done_nxt, ackin_r, ackin_nxt;
    logic tick;

    always_comb
    begin
        tick = (div_r == SCL_HALF_CYC);
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        st_nxt = st_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        bit_nxt = bit_r;
        phase_nxt = phase_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        ack_nxt = ack_r;
        ackin_nxt = ackin_r;
        done_nxt = 1'b0;
        unique case (st_r)
            TWM_IDLE:
            begin
                div_nxt = 8'h00;
                phase_nxt = 1'b0;
                bit_nxt = BIT_CNT_ZERO;
                if (cmd_start_in)
                begin
                    st_nxt = TWM_START;
                    sda_nxt = 1'b1;
                end
                else if (cmd_byte_in)
                begin
                    st_nxt = TWM_BIT;
                    sh_nxt = wr_byte_in;
                    ackin_nxt = ack_send_in;
                    sda_nxt = wr_byte_in[TYPE_MSB];
                end
                else if (cmd_stop_in)
                begin
                    st_nxt = TWM_STOP;
                    sda_nxt = 1'b0;
                end
                else if (cmd_recover_in)
                begin
                    st_nxt = TWM_RECOVER;
                    sda_nxt = 1'b1;
                end
            end
            TWM_START:
            begin
                if (tick)
                begin
                    // A low SCL rises first, a half period after SDA is freed, so the slave's late release
                    // can never look like a Stop
                    phase_nxt = phase_r ^ scl_r;
                    if (!scl_r)
                    begin
                        scl_nxt = 1'b1;
                    end
                    else if (!phase_r)
                    begin
                        sda_nxt = 1'b0;
                    end
                    else
                    begin
                        scl_nxt = 1'b0;
                        st_nxt = TWM_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            TWM_BIT:
            begin
                if (tick)
                begin
                    phase_nxt = ~phase_r;
                    if (!phase_r)
                    begin
                        scl_nxt = 1'b1;
                    end
                    else
                    begin
                        scl_nxt = 1'b0;
                        if (bit_r == BIT_CNT_ACK)
                        begin
                            ack_nxt = ~sda_s_r;
                            sda_nxt = 1'b1;
                            st_nxt = TWM_IDLE;
                            done_nxt = 1'b1;
                        end
                        else
                        begin
                            rd_nxt = {rd_r[6:0], sda_s_r};
                            bit_nxt = bit_r + 4'h1;
                            sh_nxt = {sh_r[6:0], 1'b1};
                            // After the eighth bit release so the slave can ack, or pull low to ack when ackin_r is set
                            sda_nxt = (bit_r == BIT_CNT_LAST) ? ~ackin_r : sh_r[6];
                        end
                    end
                end
            end
            TWM_STOP:
            begin
                if (tick)
                begin
                    phase_nxt = ~phase_r;
                    if (!phase_r)
                    begin
                        scl_nxt = 1'b1;
                    end
                    else
                    begin
                        sda_nxt = 1'b1;
                        st_nxt = TWM_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            TWM_RECOVER:
            begin
                if (tick)
                begin
                    phase_nxt = ~phase_r;
                    scl_nxt = ~phase_r;
                    if (phase_r)
                    begin
                        bit_nxt = bit_r + 4'h1;
                        if (sda_s_r || bit_r == RECOVER_CYCLES - 4'h1)
                        begin
                            st_nxt = TWM_IDLE;
                            done_nxt = 1'b1;
                            ack_nxt = sda_s_r;
                        end
                    end
                end
            end
            default:
            begin
                st_nxt = TWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= TWM_IDLE;
            div_r <= 8'h00;
            sh_r <= 8'h00;
            rd_r <= 8'h00;
            bit_r <= BIT_CNT_ZERO;
            phase_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            ack_r <= 1'b0;
            ackin_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            bit_r <= bit_nxt;
            phase_r <= phase_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            ack_r <= ack_nxt;
            ackin_r <= ackin_nxt;
            done_r <= done_nxt;
        end
    end

    assign bus.scl_o = scl_r;
    assign bus.scl_oe = ~scl_r;
    assign bus.sda_m_o = sda_r;
    assign bus.sda_m_oe = ~sda_r;
    assign busy_out = (st_r != TWM_IDLE);
    assign rd_byte_out = rd_r;
    assign ack_seen_out = ack_r;
    assign done_out = done_r;
endmodule

// ---- testbench/tws_bus_sva.sv ----
/* Concurrent checks on the shared two-wire bus lines.
   Assumes one master and one slave end on the bus, both on sys_clk_in. */
`timescale 1ns/1ps
module tws_bus_sva (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_r, sda_r, frame_r, addr_r, mute_r;
    logic [3:0] bit_r;
    logic [7:0] run_r;
    logic st_w, sp_w, rise_w;
    // ----------------------------------------
    // Bus event tracking
    // ----------------------------------------
    assign st_w = scl && scl_r && sda_r && !sda;
    assign sp_w = scl && scl_r && !sda_r && sda;
    assign rise_w = scl && !scl_r;
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            frame_r <= 1'b0;
            addr_r <= 1'b0;
            mute_r <= 1'b0;
            bit_r <= 4'h0;
            run_r <= 8'h00;
        end
        else
        begin
            scl_r <= scl;
            sda_r <= sda;
            frame_r <= st_w || (frame_r && !sp_w);
            addr_r <= st_w || (addr_r && !(rise_w && bit_r == 4'h8));
            // A high ninth bit leaves the slave silent until the next Start or Stop
            mute_r <= !(st_w || sp_w) && (mute_r || (rise_w && bit_r == 4'h8 && sda));
            bit_r <= (st_w || sp_w) ? 4'h0 : !rise_w ? bit_r : (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
            run_r <= (scl != scl_r) ? 8'h00 : run_r + 8'(run_r != 8'hff);
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_low_only; sda_s_oe |-> !sda_s_o; endproperty
    property p_chg_low; $changed(sda_s_oe) |-> !scl; endproperty
    property p_idle; !frame_r |-> !sda_s_oe; endproperty
    property p_addr; addr_r && bit_r < 4'h8 |-> !sda_s_oe; endproperty
    property p_ack_rel; $fell(scl) && bit_r == 4'h9 && $past(sda_s_oe) |-> ##[1:8] !sda_s_oe; endproperty
    property p_tx_rel; rise_w && bit_r == 4'h8 && sda_m_oe && !sda_m_o |-> !sda_s_oe; endproperty
    property p_nack; mute_r |-> !sda_s_oe; endproperty
    property p_phase; scl != scl_r |-> run_r >= 8'd20; endproperty
    a_low_only: assert property (p_low_only) else $error("slave drove sda high");
    a_chg_low: assert property (p_chg_low) else $error("slave sda moved with scl high");
    a_idle: assert property (p_idle) else $error("slave drove sda outside a frame");
    a_addr: assert property (p_addr) else $error("slave drove sda in address bits");
    a_ack_rel: assert property (p_ack_rel) else $error("slave kept ack past ninth clock");
    a_tx_rel: assert property (p_tx_rel) else $error("slave drove sda in master ack");
    a_nack: assert property (p_nack) else $error("slave drove sda after nack");
    a_phase: assert property (p_phase) else $error("scl phase too short");
    c_start: cover property (st_w);
    c_ack: cover property (rise_w && bit_r == 4'h8 && sda_s_oe);
    c_mute: cover property ($rose(mute_r));
endmodule

// ---- testbench/eeprom_two_wire_slave_bus_layer_test.sv ----
/* Self-checking bench: master and slave ends joined by the bus carrier.
   Assumes both ends derive all bus timing from the 100 MHz clock. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module eeprom_two_wire_slave_bus_layer_test;
    import tws_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, as = 1'b0, wbusy = 1'b0, txv = 1'b0;
    logic [3:0] c = 4'h0;
    logic [2:0] hw = 3'h0;
    logic [7:0] wb = 8'hff, txd = 8'h00, rdb, rxd, a, d;
    logic busy, ack, done, txr, rxv, wreq, sby, sel;
    logic [9:0] me;
    logic [9:0] qm[$];
    logic [7:0] qr[$];
    logic [7:0] tq[$];
    int bad_count = 0, checks = 0, nreq = 0, i, n;
    tws_bus_if bus ();
    tws_slave i_tws_slave (.sys_clk_in(clk), .resetn_in(rstn), .bus(bus.slave), .hw_select_bit_high_in(hw[2]),
        .hw_select_bit_mid_in(hw[1]), .hw_select_bit_low_in(hw[0]), .write_busy_in(wbusy), .tx_data_in(txd),
        .tx_valid_in(txv), .tx_ready_out(txr), .rx_data_out(rxd), .rx_valid_out(rxv), .write_req_out(wreq),
        .standby_out(sby), .selected_out(sel));
    tws_master i_tws_master (.sys_clk_in(clk), .resetn_in(rstn), .bus(bus.master), .cmd_start_in(c[0]),
        .cmd_byte_in(c[1]), .cmd_stop_in(c[2]), .cmd_recover_in(c[3]), .wr_byte_in(wb), .ack_send_in(as),
        .busy_out(busy), .rd_byte_out(rdb), .ack_seen_out(ack), .done_out(done));
    tws_bus_sva i_tws_bus_sva (.sys_clk_in(clk), .resetn_in(rstn), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
        .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Drivers and result monitor
    // ----------------------------------------
    // Entry layout: compare flag, ack bit, byte
    task automatic cmd(input int k, input logic [7:0] b, input logic x, input logic [9:0] e);
        int m;
        qm.push_back(e);
        @(posedge clk);
        c <= 4'(1 << k);
        wb <= b;
        as <= x;
        @(posedge clk);
        c <= 4'h0;
        for (m = 0; m < 3000 && done !== 1'b1; m++) @(negedge clk);
        if (m == 3000) bad_count++;
    endtask
    task automatic push(input logic [7:0] v, input logic x);
        @(posedge clk);
        txd <= v;
        txv <= 1'b1;
        @(negedge clk);
        `CHK(txr, x)
        @(posedge clk);
        txv <= 1'b0;
    endtask
    task automatic complete_run();
        $display("bad_count=%0d checks=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk)
    begin
        if (done === 1'b1 && qm.size() > 0)
        begin
            me = qm.pop_front();
            if (me[9]) `CHK({ack, rdb}, me[8:0])
        end
        if (rxv === 1'b1) `CHK(rxd, (qr.size() > 0) ? qr.pop_front() : 8'hxx)
        if (wreq === 1'b1) nreq++;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(92756));
        hw = 3'($urandom);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(sby, 1'b1)
        cmd(0, 8'hff, 0, 10'h0);
        `CHK(sby, 1'b0)
        a = {4'ha, hw, 1'b0};
        cmd(1, a, 0, {2'b11, a});
        `CHK(sel, 1'b1)
        repeat (3)
        begin
            d = 8'($urandom);
            qr.push_back(d);
            cmd(1, d, 0, {2'b11, d});
        end
        wbusy <= 1'b1;
        cmd(2, 8'hff, 0, 10'h0);
        repeat (8) @(negedge clk);
        `CHK(sby, 1'b0)
        wbusy <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK(sby, 1'b1)
        for (i = 0; i < 3; i++)
        begin
            wbusy <= (i == 2);
            d = (i == 0) ? {4'h5, hw, 1'b0} : {4'ha, hw ^ ((i == 1) ? 3'h4 : 3'h0), 1'b0};
            cmd(0, 8'hff, 0, 10'h0);
            cmd(1, d, 0, {2'b10, d});
            cmd(1, 8'h3c, 0, {2'b10, 8'h3c});
            cmd(2, 8'hff, 0, 10'h0);
        end
        wbusy <= 1'b0;
        for (i = 0; i < 5; i++)
        begin
            d = 8'($urandom) | 8'h80;
            push(d, i < 4);
            if (i < 4) tq.push_back(d);
        end
        cmd(0, 8'hff, 0, 10'h0);
        cmd(1, a, 0, {2'b11, a});
        cmd(0, 8'hff, 0, 10'h0);
        cmd(1, a | 8'h01, 0, {2'b11, a | 8'h01});
        for (i = 0; i < 5; i++) cmd(1, 8'hff, i < 4, {1'b1, i < 4, (i < 4) ? tq[i] : 8'hff});
        cmd(2, 8'hff, 0, 10'h0);
        for (n = 0; n < 100 && sby !== 1'b1; n++) @(negedge clk);
        `CHK(sby, 1'b1)
        // Second byte of zeros leaves the slave holding sda low when the read is cut off
        d = 8'($urandom) | 8'h80;
        push(d, 1'b1);
        push(8'h00, 1'b1);
        cmd(0, 8'hff, 0, 10'h0);
        cmd(1, a | 8'h01, 0, {2'b11, a | 8'h01});
        cmd(1, 8'hff, 1, {2'b11, d});
        cmd(3, 8'hff, 0, 10'h0);
        `CHK(ack, 1'b1)
        cmd(0, 8'hff, 0, 10'h0);
        cmd(2, 8'hff, 0, 10'h0);
        `CHK(nreq, 1)
        complete_run();
    end
    // Roughly 16k cycles of traffic expected; nearly four times that means a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule
